// *** src/cpio_cpu_end.sv ***
/*
 Processor end of the peripheral connector, with a classic Wishbone slave
 for software. Assumes the link inputs are asynchronous pins.
*/
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module cpio_cpu_end
  import cpio_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Prime button and prime event
  input wire logic prime_button_i,
  output logic prime_event_o,
  // Link
  cpio_link_if.cpu link
);
  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [12:0] sync_a;
  logic [12:0] sync_b;
  logic [12:0] sync_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_prev <= '0;
    end else begin
      sync_a <= {link.prime_line, link.halt_strobe, link.ready_busy_level, link.special_function_flag,
                 link.input_data_strobe, link.input_data_upper, link.input_data_lower};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end
  // Data lines ride the strobe's own flops, so a capture stays aligned with it
  logic in_rise, halt_rise, prime_rise, ready_s;
  assign in_rise = sync_b[8] & ~sync_prev[8];
  assign halt_rise = sync_b[11] & ~sync_prev[11];
  assign prime_rise = sync_b[12] & ~sync_prev[12];
  assign ready_s = sync_b[10];
  // ************************************************************
  // Bus decode
  // ************************************************************
  logic bus_wr, bus_rd;
  assign bus_wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  assign bus_rd = cyc_i & stb_i & ~we_i & ~ack_o;
  logic cmd_go;
  assign cmd_go = bus_wr && adr_i == REG_CMD;
  // ************************************************************
  // Status and nibble registers
  // ************************************************************
  logic [3:0] upper_data_nibble_reg;
  logic [3:0] lower_data_nibble_reg;
  logic input_lockout_flag;
  logic special_function_status_bit;
  logic halt_bit;
  logic accept;
  assign accept = in_rise & ~input_lockout_flag;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper_data_nibble_reg <= NIBBLE_RST;
      lower_data_nibble_reg <= NIBBLE_RST;
    end else if (accept) begin
      upper_data_nibble_reg <= sync_b[7:4];
      lower_data_nibble_reg <= sync_b[3:0];
    end else if (bus_wr && adr_i == REG_DATA) begin
      upper_data_nibble_reg <= dat_i[7:4];
      lower_data_nibble_reg <= dat_i[3:0];
    end
  end
  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_lockout_flag <= 1'b0;
      special_function_status_bit <= 1'b0;
    end else if (accept) begin
      input_lockout_flag <= 1'b1;
      special_function_status_bit <= sync_b[9];
    end else if (bus_wr && adr_i == REG_ST1) begin
      input_lockout_flag <= dat_i[ST1_LOCKOUT_BIT];
      special_function_status_bit <= dat_i[ST1_SPECIAL_BIT];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_bit <= 1'b0;
    end else if (halt_rise) begin
      halt_bit <= 1'b1;
    end else if (bus_wr && adr_i == REG_ST3) begin
      halt_bit <= dat_i[ST3_HALT_BIT];
    end
  end
  // ************************************************************
  // Control-output instruction
  // ************************************************************
  logic [7:0] control_output_instruction;
  assign control_output_instruction = dat_i[7:0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.device_select_bits <= SEL_RST;
      link.legacy_select_bits <= LEGACY_RST;
    end else if (cmd_go && control_output_instruction[CIO_SELECT_BIT]) begin
      link.device_select_bits <= {upper_data_nibble_reg[0], lower_data_nibble_reg};
      link.legacy_select_bits <= upper_data_nibble_reg[3:1];
    end
  end
  logic en_pulse, data_pulse, prime_pulse;
  cpio_pulse #(.LEN(STROBE_CYCLES)) u_enable (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(cmd_go && control_output_instruction[CIO_ENABLE_BIT]),
    .pulse_o(en_pulse)
  );
  cpio_pulse #(.LEN(STROBE_CYCLES)) u_data (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(cmd_go && control_output_instruction[CIO_DATA_BIT]),
    .pulse_o(data_pulse)
  );
  cpio_pulse #(.LEN(STROBE_CYCLES)) u_prime (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(prime_button_i),
    .pulse_o(prime_pulse)
  );
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.device_enable_strobe <= 1'b0;
      link.output_data_strobe <= 1'b0;
      link.prime_cpu_o <= 1'b0;
      link.prime_cpu_oe <= 1'b0;
      link.lockout_level_out <= 1'b0;
    end else begin
      link.device_enable_strobe <= en_pulse;
      link.output_data_strobe <= data_pulse;
      link.prime_cpu_o <= prime_pulse;
      link.prime_cpu_oe <= prime_pulse;
      link.lockout_level_out <= input_lockout_flag;
    end
  end
  // Present nibbles; serial bit rides on the top line
  // A data command during a running strobe is dropped, so the lines hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.out_upper <= NIBBLE_RST;
      link.out_lower <= NIBBLE_RST;
    end else if (cmd_go && control_output_instruction[CIO_DATA_BIT] && !data_pulse) begin
      link.out_upper <= upper_data_nibble_reg;
      link.out_lower <= lower_data_nibble_reg;
    end
  end
  // Prime event from either end; own strobe also seen on the line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prime_event_o <= 1'b0;
    end else begin
      prime_event_o <= prime_rise;
    end
  end
  // ************************************************************
  // Bus answer, ack registered one cycle after the strobe
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (bus_rd) begin
        case (adr_i)
          REG_DATA: dat_o <= {24'h000000, upper_data_nibble_reg, lower_data_nibble_reg};
          REG_ST3: dat_o <= {28'h0000000, 1'b0, halt_bit, 1'b0, ready_s};
          REG_ST1: dat_o <= {29'h00000000, special_function_status_bit, input_lockout_flag, 1'b0};
          default: dat_o <= '0;
        endcase
      end
    end
  end
endmodule : cpio_cpu_end
`default_nettype wire

// *** src/cpio_pkg.sv ***
/*
 Package for the processor peripheral connector: field positions, reset
 values and strobe timing shared by both ends and the checker.
 Assumes a single 100 MHz clock on every end.
*/
package cpio_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int STROBE_US = 5;
  // Least time, so whole cycles; 5 us at 100 MHz is exact
  localparam int STROBE_CYCLES = STROBE_US * CLK_MHZ;
  localparam int READY_US = 5;
  localparam int READY_CYCLES = READY_US * CLK_MHZ;
  localparam int CNT_W = 10;
  // ************************************************************
  // Control-output instruction bit positions
  // ************************************************************
  localparam int CIO_DATA_BIT = 5;
  localparam int CIO_ENABLE_BIT = 6;
  localparam int CIO_SELECT_BIT = 7;
  // Serial bit rides on lower-data line 0 in and upper-data line 3 out
  localparam int SERIAL_IN_BIT = 0;
  localparam int SERIAL_OUT_BIT = 7;
  // ************************************************************
  // Status bit positions and reset values
  // ************************************************************
  localparam int ST1_LOCKOUT_BIT = 1;
  localparam int ST1_SPECIAL_BIT = 2;
  localparam int ST3_READY_BIT = 0;
  localparam int ST3_HALT_BIT = 2;
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [4:0] SEL_RST = 5'h00;
  localparam logic [2:0] LEGACY_RST = 3'h0;
  // ************************************************************
  // Wishbone register offsets (byte addresses)
  // ************************************************************
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_ST1 = 4'h8;
  localparam logic [3:0] REG_ST3 = 4'hc;
endpackage : cpio_pkg

// *** src/cpio_link_if.sv ***
/*
 Connector between processor end and peripheral end.
 Assumes both ends share clk; prime is a wired-or of both enables.
*/
`timescale 1ns/10ps
`default_nettype none
interface cpio_link_if;
  logic [3:0] input_data_upper;
  logic [3:0] input_data_lower;
  logic input_data_strobe;
  logic special_function_flag;
  logic ready_busy_level;
  logic halt_strobe;
  logic [3:0] out_upper;
  logic [3:0] out_lower;
  logic output_data_strobe;
  logic device_enable_strobe;
  logic [4:0] device_select_bits;
  logic [2:0] legacy_select_bits;
  logic lockout_level_out;
  logic prime_cpu_o;
  logic prime_cpu_oe;
  logic prime_dev_o;
  logic prime_dev_oe;
  logic prime_line;
  // Line is high when either end drives its strobe
  assign prime_line = (prime_cpu_oe & prime_cpu_o) | (prime_dev_oe & prime_dev_o);
  modport cpu (
    input input_data_upper, input_data_lower, input_data_strobe, special_function_flag,
    input ready_busy_level, halt_strobe, prime_line,
    output out_upper, out_lower, output_data_strobe, device_enable_strobe,
    output device_select_bits, legacy_select_bits, lockout_level_out, prime_cpu_o, prime_cpu_oe
  );
  modport dev (
    output input_data_upper, input_data_lower, input_data_strobe, special_function_flag,
    output ready_busy_level, halt_strobe, prime_dev_o, prime_dev_oe,
    input out_upper, out_lower, output_data_strobe, device_enable_strobe,
    input device_select_bits, legacy_select_bits, lockout_level_out, prime_line
  );
endinterface : cpio_link_if
`default_nettype wire

// *** src/cpio_pulse.sv ***
/*
 Fixed-length strobe generator: a start pulse yields a strobe of LEN cycles.
 Assumes start comes from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cpio_pulse
  import cpio_pkg::*;
#(
  parameter int LEN = STROBE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  output logic pulse_o
);
  logic [CNT_W-1:0] count;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      pulse_o <= 1'b0;
    end else if (start_i && !pulse_o) begin
      count <= CNT_W'(LEN - 1);
      pulse_o <= 1'b1;
    end else if (pulse_o) begin
      if (count == '0) begin
        pulse_o <= 1'b0;
      end else begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : cpio_pulse
`default_nettype wire

// *** src/cpio_dev_end.sv ***
/*
 Peripheral end: a keyboard-like controller with a switch address.
 Assumes the processor end drives the link from flops on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cpio_dev_end
  import cpio_pkg::*;
#(
  parameter bit IS_KEYBOARD = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // User side
  input wire logic [4:0] address_switch_i,
  input wire logic send_i,
  input wire logic [7:0] send_data_i,
  input wire logic special_i,
  input wire logic halt_button_i,
  input wire logic prime_button_i,
  input wire logic dev_ready_i,
  output logic enabled_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic prime_seen_o,
  // Link
  cpio_link_if.dev link
);
  logic en_prev, data_prev, prime_prev;
  logic [CNT_W-1:0] ready_cnt;
  logic in_pulse, halt_pulse, prime_pulse;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_prev <= 1'b0;
      data_prev <= 1'b0;
      prime_prev <= 1'b0;
      enabled_o <= 1'b0;
    end else begin
      en_prev <= link.device_enable_strobe;
      data_prev <= link.output_data_strobe;
      prime_prev <= link.prime_line;
      // Enable on match, drop otherwise; switch address
      if (link.device_enable_strobe && !en_prev) begin
        enabled_o <= link.device_select_bits == address_switch_i;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_o <= '0;
      rx_valid_o <= 1'b0;
      prime_seen_o <= 1'b0;
    end else begin
      rx_valid_o <= enabled_o && link.output_data_strobe && !data_prev;
      if (enabled_o && link.output_data_strobe && !data_prev) begin
        rx_data_o <= {link.out_upper, link.out_lower};
      end
      prime_seen_o <= link.prime_line && !prime_prev;
    end
  end
  // Ready level valid within 5 us
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_cnt <= '0;
    end else if ((link.device_enable_strobe && !en_prev) || (link.output_data_strobe && !data_prev)) begin
      ready_cnt <= CNT_W'(READY_CYCLES - 1);
    end else if (ready_cnt != '0) begin
      ready_cnt <= ready_cnt - 1'b1;
    end
  end
  // Five microsecond input strobe; gated send
  cpio_pulse #(.LEN(STROBE_CYCLES)) u_in (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(send_i && enabled_o && !link.lockout_level_out),
    .pulse_o(in_pulse)
  );
  cpio_pulse #(.LEN(STROBE_CYCLES)) u_halt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(halt_button_i),
    .pulse_o(halt_pulse)
  );
  cpio_pulse #(.LEN(STROBE_CYCLES)) u_prime (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(prime_button_i),
    .pulse_o(prime_pulse)
  );
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.input_data_upper <= NIBBLE_RST;
      link.input_data_lower <= NIBBLE_RST;
      link.special_function_flag <= 1'b0;
      link.input_data_strobe <= 1'b0;
      link.halt_strobe <= 1'b0;
      link.ready_busy_level <= 1'b0;
      link.prime_dev_o <= 1'b0;
      link.prime_dev_oe <= 1'b0;
    end else begin
      if (send_i && !in_pulse) begin
        // Serial devices put their bit on lower line 0
        link.input_data_upper <= send_data_i[7:4];
        link.input_data_lower <= send_data_i[3:0];
        link.special_function_flag <= IS_KEYBOARD & special_i;
      end
      link.input_data_strobe <= in_pulse;
      link.halt_strobe <= halt_pulse & IS_KEYBOARD;
      link.ready_busy_level <= enabled_o & dev_ready_i & (ready_cnt == '0);
      link.prime_dev_o <= prime_pulse;
      link.prime_dev_oe <= prime_pulse;
    end
  end
endmodule : cpio_dev_end
`default_nettype wire

// *** verification/cpio_link_sva.sv ***
/*
 Checker for the link between the two ends: strobe lengths, lockout, holds.
 Assumes it sits beside the link interface and shares its clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cpio_link_sva
  import cpio_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link strobes and levels
  input wire logic input_data_strobe,
  input wire logic output_data_strobe,
  input wire logic device_enable_strobe,
  input wire logic prime_line,
  input wire logic lockout_level_out,
  // Link buses
  input wire logic [3:0] out_upper,
  input wire logic [3:0] out_lower,
  input wire logic [4:0] device_select_bits,
  input wire logic [2:0] legacy_select_bits
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ********
  // Strobe length counters
  // ********
  // Cleared while low, so at a falling edge each holds the whole length
  logic [CNT_W-1:0] en_cnt;
  logic [CNT_W-1:0] od_cnt;
  logic [CNT_W-1:0] in_cnt;
  logic [CNT_W-1:0] pr_cnt;
  always_ff @(posedge clk_i) begin
    en_cnt <= (rst_i || !device_enable_strobe) ? '0 : en_cnt + 1'b1;
    od_cnt <= (rst_i || !output_data_strobe) ? '0 : od_cnt + 1'b1;
    in_cnt <= (rst_i || !input_data_strobe) ? '0 : in_cnt + 1'b1;
    pr_cnt <= (rst_i || !prime_line) ? '0 : pr_cnt + 1'b1;
  end
  // ********
  // Assertions
  // ********
  en_len_a: assert property ($fell(device_enable_strobe) |-> en_cnt == STROBE_CYCLES)
    else $error("enable strobe length wrong");
  od_len_a: assert property ($fell(output_data_strobe) |-> od_cnt == STROBE_CYCLES)
    else $error("data strobe length wrong");
  in_len_a: assert property ($fell(input_data_strobe) |-> in_cnt >= STROBE_CYCLES)
    else $error("input strobe too short");
  prime_len_a: assert property ($fell(prime_line) |-> pr_cnt == STROBE_CYCLES)
    else $error("prime strobe length wrong");
  lock_set_a: assert property ($rose(input_data_strobe) && !lockout_level_out |-> ##[1:8] lockout_level_out)
    else $error("lockout not set by input");
  in_blocked_a: assert property (lockout_level_out |-> !$rose(input_data_strobe))
    else $error("input strobe during lockout");
  od_hold_a: assert property (output_data_strobe && $past(output_data_strobe) |-> $stable({out_upper, out_lower}))
    else $error("output data moved in strobe");
  sel_hold_a: assert property (device_enable_strobe && $past(device_enable_strobe) |-> $stable(device_select_bits))
    else $error("select bits moved in strobe");
  legacy_hold_a: assert property (output_data_strobe && $past(output_data_strobe) |-> $stable(legacy_select_bits))
    else $error("legacy bits moved in strobe");
  en_c: cover property ($rose(device_enable_strobe));
  in_c: cover property ($rose(input_data_strobe));
  pr_c: cover property ($rose(prime_line));
endmodule : cpio_link_sva
`default_nettype wire

// *** verification/test_cpu_peripheral_io_connector.sv ***
/*
 Bench for the peripheral connector: both ends joined by the link, software
 side over classic Wishbone, device user side driven directly.
 Assumes one 100 MHz clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module test_cpu_peripheral_io_connector
  import cpio_pkg::*;
;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, prime_button_i, prime_event_o;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd_val;
  logic [4:0] address_switch_i;
  logic send_i, special_i, halt_button_i, dev_prime_i, dev_ready_i, enabled_o, rx_valid_o, prime_seen_o;
  logic [7:0] send_data_i, rx_data_o;
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  cpio_link_if cpio_link_if_inst ();
  cpio_cpu_end cpio_cpu_end_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .prime_button_i(prime_button_i),
    .prime_event_o(prime_event_o), .link(cpio_link_if_inst));
  cpio_dev_end cpio_dev_end_inst (.clk_i(clk_i), .rst_i(rst_i), .address_switch_i(address_switch_i),
    .send_i(send_i), .send_data_i(send_data_i), .special_i(special_i), .halt_button_i(halt_button_i),
    .prime_button_i(dev_prime_i), .dev_ready_i(dev_ready_i), .enabled_o(enabled_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .prime_seen_o(prime_seen_o), .link(cpio_link_if_inst));
  cpio_link_sva cpio_link_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
    .input_data_strobe(cpio_link_if_inst.input_data_strobe), .output_data_strobe(cpio_link_if_inst.output_data_strobe),
    .device_enable_strobe(cpio_link_if_inst.device_enable_strobe), .prime_line(cpio_link_if_inst.prime_line),
    .lockout_level_out(cpio_link_if_inst.lockout_level_out), .out_upper(cpio_link_if_inst.out_upper),
    .out_lower(cpio_link_if_inst.out_lower), .device_select_bits(cpio_link_if_inst.device_select_bits),
    .legacy_select_bits(cpio_link_if_inst.legacy_select_bits));
  // ********
  // Shared tasks
  // ********
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    chk_word({31'h0, got}, {31'h0, exp}, msg);
  endtask : chk_bit
  // Classic cycle; held until ack is sampled, released after it
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // No answer time assumed; only the watchdog ends a dead wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd_val = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    chk_bit(ack_o, 1'b0, "ack held");
  endtask : wb
  function automatic logic probe(input int s);
    case (s)
      0: return cpio_link_if_inst.device_enable_strobe;
      1: return cpio_link_if_inst.output_data_strobe;
      2: return cpio_link_if_inst.lockout_level_out;
      3: return rx_valid_o;
      4: return prime_seen_o;
      5: return prime_event_o;
      6: return enabled_o;
      default: return cpio_link_if_inst.prime_line;
    endcase
  endfunction : probe
  // Bounded wait, so a dead handshake shows as a mismatch, not a hang
  task automatic wait_lvl(input int s, input logic lvl, input int lim, input string msg);
    int k;
    k = 0;
    while (probe(s) !== lvl && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    chk_bit(probe(s), lvl, msg);
  endtask : wait_lvl
  task automatic send(input logic [7:0] d, input logic sp);
    @(posedge clk_i);
    send_data_i <= d;
    special_i <= sp;
    send_i <= 1'b1;
    @(posedge clk_i);
    send_i <= 1'b0;
  endtask : send
  task automatic pulse_cmd(input logic [31:0] data, input logic [31:0] cmd);
    wb(1'b1, REG_DATA, data);
    wb(1'b1, REG_CMD, cmd);
  endtask : pulse_cmd
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    wb(1'b0, REG_ST1, 32'h0);
    chk_word(rd_val, 32'h0, "status one reset");
    wb(1'b0, REG_ST3, 32'h0);
    chk_word(rd_val, 32'h0, "status three reset");
    wb(1'b1, 4'h2, 32'hff);
    wb(1'b0, REG_DATA, 32'h0);
    chk_word(rd_val, 32'h0, "data reset");
    wb(1'b0, 4'h2, 32'h0);
    chk_word(rd_val, 32'h0, "unmapped read");
    $display("test regs done");
  endtask : t_regs
  task automatic t_select;
    pulse_cmd(32'he0, 32'h80);
    repeat (4) @(posedge clk_i);
    chk_word({29'h0, cpio_link_if_inst.legacy_select_bits}, 32'h7, "legacy bits");
    chk_word({27'h0, cpio_link_if_inst.device_select_bits}, 32'h0, "select zero");
    pulse_cmd(32'h13, 32'hc0);
    wait_lvl(0, 1'b1, 8, "enable strobe");
    chk_word({27'h0, cpio_link_if_inst.device_select_bits}, 32'h13, "select bits");
    chk_word({29'h0, cpio_link_if_inst.legacy_select_bits}, 32'h0, "legacy zero");
    wait_lvl(0, 1'b0, 600, "enable strobe end");
    wait_lvl(6, 1'b1, 8, "device enabled");
    repeat (READY_CYCLES + 8) @(posedge clk_i);
    wb(1'b0, REG_ST3, 32'h0);
    chk_bit(rd_val[ST3_READY_BIT], 1'b1, "ready bit");
    $display("test select done");
  endtask : t_select
  task automatic t_output;
    pulse_cmd(32'hc9, 32'h20);
    wait_lvl(1, 1'b1, 8, "data strobe");
    chk_word({24'h0, cpio_link_if_inst.out_upper, cpio_link_if_inst.out_lower}, 32'hc9, "output data");
    chk_bit(cpio_link_if_inst.out_upper[3], 1'b1, "serial out line");
    wait_lvl(3, 1'b1, 600, "device got data");
    chk_word({24'h0, rx_data_o}, 32'hc9, "device data");
    wait_lvl(1, 1'b0, 600, "data strobe end");
    $display("test output done");
  endtask : t_output
  task automatic t_input;
    send(8'ha5, 1'b1);
    wait_lvl(2, 1'b1, 64, "lockout set");
    wb(1'b0, REG_DATA, 32'h0);
    chk_word(rd_val, 32'ha5, "captured code");
    wb(1'b0, REG_ST1, 32'h0);
    chk_word(rd_val, 32'h6, "lockout and special");
    // Second send lands while locked out and must leave the data alone
    send(8'h3c, 1'b0);
    repeat (700) @(posedge clk_i);
    wb(1'b0, REG_DATA, 32'h0);
    chk_word(rd_val, 32'ha5, "locked input ignored");
    wb(1'b1, REG_ST1, 32'h0);
    wait_lvl(2, 1'b0, 8, "lockout cleared");
    send(8'h3c, 1'b0);
    wait_lvl(2, 1'b1, 64, "lockout set again");
    wb(1'b0, REG_DATA, 32'h0);
    chk_word(rd_val, 32'h3c, "second capture");
    wb(1'b0, REG_ST1, 32'h0);
    chk_word(rd_val, 32'h2, "special clear");
    $display("test input done");
  endtask : t_input
  task automatic t_halt_prime;
    @(posedge clk_i);
    halt_button_i <= 1'b1;
    @(posedge clk_i);
    halt_button_i <= 1'b0;
    for (n = 0; n < 40; n++) begin
      wb(1'b0, REG_ST3, 32'h0);
      if (rd_val[ST3_HALT_BIT] === 1'b1) break;
    end
    chk_bit(rd_val[ST3_HALT_BIT], 1'b1, "halt bit");
    prime_button_i <= 1'b1;
    @(posedge clk_i);
    prime_button_i <= 1'b0;
    wait_lvl(4, 1'b1, 64, "device saw prime");
    wait_lvl(7, 1'b0, 600, "prime end");
    dev_prime_i <= 1'b1;
    @(posedge clk_i);
    dev_prime_i <= 1'b0;
    wait_lvl(5, 1'b1, 64, "processor saw prime");
    wait_lvl(7, 1'b0, 600, "prime end");
    $display("test halt prime done");
  endtask : t_halt_prime
  task automatic t_disable;
    pulse_cmd(32'h07, 32'hc0);
    wait_lvl(0, 1'b1, 8, "enable strobe");
    wait_lvl(0, 1'b0, 600, "enable strobe end");
    wait_lvl(6, 1'b0, 8, "device released");
    wb(1'b1, REG_ST1, 32'h0);
    send(8'h55, 1'b0);
    repeat (16) @(posedge clk_i);
    chk_bit(probe(2), 1'b0, "disabled device sent");
    wb(1'b0, REG_DATA, 32'h0);
    chk_word(rd_val, 32'h07, "data kept while disabled");
    $display("test disable done");
  endtask : t_disable
  // ********
  // Clock, watchdog and sequence
  // ********
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    $display("mismatch at %0t: watchdog", $time);
    wrap_up();
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, prime_button_i, send_i, special_i, halt_button_i, dev_prime_i} = 9'h100;
    adr_i = 4'h0;
    sel_i = 4'hf;
    dat_i = 32'h0;
    send_data_i = 8'h0;
    address_switch_i = 5'h13;
    dev_ready_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_select();
    t_output();
    t_input();
    t_halt_prime();
    t_disable();
    wrap_up();
  end
endmodule : test_cpu_peripheral_io_connector
`default_nettype wire
